// file: vpg_gpio.sv
// Video port pin GPIO: function select, direction, input and output data
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// R1: Bit 12 sets data pins 15-12 direction
// R2: Bit 8 sets data pins 9-8 direction
// R3: Bit 4 sets data pins 7-4 direction
// R4: Bit 0 sets data pins 3-2 direction
// R5: Reserved bits read zero, writes ignored
// R6: Input register read-only, always shows pins
// R7: Input bits 22-20 show control pins 3-1
// R8: Input bits 19-2 show data pins
// R9: Output bit drives pin only as output
// R10: Output writes leave non-GPIO-output pins alone
// R11: Direct output write loads writable bits
// R12: Output read returns register, not pins
// R13: Set alias one forces bit high
// R14: Clear alias one forces bit low
// R15: Direction acts only on GPIO-selected pins
// R16: Bits 22-20, 16 set control, data 19-16
// R17: Alias zero no effect, set reads zero
// R18: Pins synchronised before input register
// R19: Simultaneous set and clear: clear wins

module vpg_gpio
    import vpg_pkg::*;
(
    input  wire logic            core_clk,
    input  wire logic            rstn,
    input  wire vpg_pkg::vpg_req_t reg_req,
    output var  logic [31:0]     reg_rdata,
    input  wire logic [22:0]     pin_in,
    input  wire vpg_pkg::vpg_pin_t video_drive,
    output var  vpg_pkg::vpg_pin_t pin_drive
);
    import vpg_pkg::*;

    // ==========================================================
    // Decode helpers
    function automatic logic [REG_W-1:0] dir_expand(input logic [REG_W-1:0] dir);
        logic [REG_W-1:0] m;
        m = dir & CTL_MASK;
        if (dir[DIR_D3_2])   m = m | GRP_D3_2;     // R4
        if (dir[DIR_D7_4])   m = m | GRP_D7_4;     // R3
        if (dir[DIR_D9_8])   m = m | GRP_D9_8;     // R2
        if (dir[DIR_D15_12]) m = m | GRP_D15_12;   // R1
        if (dir[DIR_D19_16]) m = m | GRP_D19_16;   // R16
        return m;
    endfunction : dir_expand

    function automatic logic [REG_W-1:0] gpio_expand(input logic [REG_W-1:0] fs);
        logic [REG_W-1:0] m;
        m = fs & CTL_MASK;
        if (fs[FS_DATA_LO]) m = m | GRP_D9_2;
        if (fs[FS_DATA_HI]) m = m | GRP_D19_12;
        return m;
    endfunction : gpio_expand

    function automatic logic [REG_W-1:0] widen(input logic [PIN_W-1:0] v);
        return {{(REG_W-PIN_W){1'b0}}, v};
    endfunction : widen

    // ==========================================================
    // State
    typedef struct packed {
        logic [REG_W-1:0] func;
        logic [REG_W-1:0] dir;
        logic [REG_W-1:0] dout;
        logic [PIN_W-1:0] sync1;
        logic [PIN_W-1:0] sync2;
        logic [PIN_W-1:0] sync3;
        logic [PIN_W-1:0] level;
        logic [REG_W-1:0] rdata;
        logic [PIN_W-1:0] pout;
        logic [PIN_W-1:0] poe;
    } vpg_state_t;

    vpg_state_t       st_ff;
    vpg_state_t       nxt_st;
    logic [REG_W-1:0] gpio_m;
    logic [REG_W-1:0] out_m;

    assign gpio_m = gpio_expand(st_ff.func);
    assign out_m  = gpio_m & dir_expand(st_ff.dir);   // R15

    // ==========================================================
    // Next state
    always_comb begin
        logic [REG_W-1:0] set_m;
        logic [REG_W-1:0] clr_m;
        logic [PIN_W-1:0] agree;
        set_m  = REG_RESET;
        clr_m  = REG_RESET;
        agree  = '0;
        nxt_st = st_ff;

        // Writes; reserved positions never stored
        if (reg_req.wr) begin
            unique case (reg_req.addr)
                OFS_FUNC: nxt_st.func = reg_req.wdata & FUNC_WMASK;
                OFS_DIR:  nxt_st.dir  = reg_req.wdata & DIR_WMASK;   // R5
                OFS_OUT:  nxt_st.dout = reg_req.wdata & DATA_MASK;   // R11
                OFS_SET:  set_m       = reg_req.wdata & DATA_MASK;   // R13
                OFS_CLR:  clr_m       = reg_req.wdata & DATA_MASK;   // R14
                default:  ;
            endcase
        end
        // Zero bits of an alias leave the bit alone; clear applied last
        nxt_st.dout = (nxt_st.dout | set_m) & ~clr_m;   // R17 R19

        // Three-stage capture, a change counts once stages two and three agree
        nxt_st.sync1 = pin_in;                           // R18
        nxt_st.sync2 = st_ff.sync1;
        nxt_st.sync3 = st_ff.sync2;
        agree        = ~(st_ff.sync2 ^ st_ff.sync3);
        nxt_st.level = (st_ff.sync2 & agree) | (st_ff.level & ~agree);   // R18

        // Read data, valid the cycle after the strobe only
        nxt_st.rdata = REG_RESET;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                OFS_FUNC: nxt_st.rdata = st_ff.func;
                OFS_DIR:  nxt_st.rdata = st_ff.dir;                        // R5
                OFS_IN:   nxt_st.rdata = widen(st_ff.level) & DATA_MASK;   // R6 R7 R8
                OFS_OUT:  nxt_st.rdata = st_ff.dout;                       // R12
                default:  nxt_st.rdata = REG_RESET;                        // R17
            endcase
        end

        // Pin drive: GPIO outputs take the register, non-GPIO pins keep video function
        nxt_st.pout = (st_ff.dout[PIN_W-1:0] & out_m[PIN_W-1:0])          // R9
                    | (video_drive.out & ~gpio_m[PIN_W-1:0]);             // R10
        nxt_st.poe  = (out_m[PIN_W-1:0]                                   // R1 R2 R3 R4 R16
                    | (video_drive.oe & ~gpio_m[PIN_W-1:0]))
                    & DATA_MASK[PIN_W-1:0];
    end

    // ==========================================================
    // Registers; level reset to zero so early reads are defined
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reg_rdata     = st_ff.rdata;
    assign pin_drive     = '{out: st_ff.pout, oe: st_ff.poe};

    // ==========================================================
    // Checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rstn);

    chk_dir_resv: assert property ( // R5
        reg_req.rd && reg_req.addr == OFS_DIR |=> (reg_rdata & ~DIR_WMASK) == REG_RESET
    ) else $error("reserved direction bits read nonzero");

    chk_grp_15_12: assert property ( // R1
        st_ff.func[FS_DATA_HI] && st_ff.dir[DIR_D15_12]
        |=> (widen(pin_drive.oe) & GRP_D15_12) == GRP_D15_12
    ) else $error("data pins 15-12 not driven as outputs");

    chk_grp_9_8: assert property ( // R2
        st_ff.func[FS_DATA_LO] && !st_ff.dir[DIR_D9_8]
        |=> (widen(pin_drive.oe) & GRP_D9_8) == REG_RESET
    ) else $error("data pins 9-8 driven while inputs");

    chk_grp_7_4: assert property ( // R3
        st_ff.func[FS_DATA_LO] && st_ff.dir[DIR_D7_4]
        |=> (widen(pin_drive.oe) & GRP_D7_4) == GRP_D7_4
    ) else $error("data pins 7-4 not driven as outputs");

    chk_grp_3_2: assert property ( // R4
        st_ff.func[FS_DATA_LO]
        |=> (widen(pin_drive.oe) & GRP_D3_2) == ($past(st_ff.dir[DIR_D3_2]) ? GRP_D3_2 : REG_RESET)
    ) else $error("data pins 3-2 direction wrong");

    chk_ctl_dir: assert property ( // R16
        ##1 (widen(pin_drive.oe) & $past(gpio_m) & CTL_MASK)
            == ($past(st_ff.dir) & $past(gpio_m) & CTL_MASK)
    ) else $error("control pin direction wrong");

    chk_in_read: assert property ( // R6
        reg_req.rd && reg_req.addr == OFS_IN
        |=> reg_rdata == (widen($past(st_ff.level)) & DATA_MASK)
    ) else $error("input register read mismatch");

    chk_in_resv: assert property ( // R8
        reg_req.rd && reg_req.addr == OFS_IN |=> (reg_rdata & ~DATA_MASK) == REG_RESET
    ) else $error("input reserved bits nonzero");

    chk_in_stable: assert property ( // R18
        ##1 (st_ff.level != $past(st_ff.level))
        |-> ((st_ff.level ^ $past(st_ff.level)) & ($past(st_ff.sync2) ^ $past(st_ff.sync3))) == '0
    ) else $error("input level changed without agreement");

    chk_ctl_level: assert property ( // R7
        (st_ff.sync2[PIN_W-1 -: 3] == st_ff.sync3[PIN_W-1 -: 3])
        |=> st_ff.level[PIN_W-1 -: 3] == $past(st_ff.sync2[PIN_W-1 -: 3])
    ) else $error("control pin level not captured");

    chk_pin_drive: assert property ( // R9
        ##1 (widen(pin_drive.out) & $past(out_m)) == ($past(st_ff.dout) & $past(out_m))
    ) else $error("GPIO output level wrong");

    chk_non_gpio: assert property ( // R10
        ##1 (widen(pin_drive.out) & ~$past(gpio_m) & DATA_MASK)
            == (widen($past(video_drive.out)) & ~$past(gpio_m) & DATA_MASK)
    ) else $error("non-GPIO pin disturbed");

    chk_out_write: assert property ( // R11
        reg_req.wr && reg_req.addr == OFS_OUT |=> st_ff.dout == ($past(reg_req.wdata) & DATA_MASK)
    ) else $error("direct output write not loaded");

    chk_out_read: assert property ( // R12
        reg_req.rd && reg_req.addr == OFS_OUT |=> reg_rdata == $past(st_ff.dout)
    ) else $error("output read not register value");

    chk_set_alias: assert property ( // R13
        reg_req.wr && reg_req.addr == OFS_SET
        |=> st_ff.dout == ($past(st_ff.dout) | ($past(reg_req.wdata) & DATA_MASK))
    ) else $error("set alias wrong");

    chk_clr_alias: assert property ( // R14
        reg_req.wr && reg_req.addr == OFS_CLR
        |=> st_ff.dout == ($past(st_ff.dout) & ~$past(reg_req.wdata))
    ) else $error("clear alias wrong");

    chk_set_read: assert property ( // R17
        reg_req.rd && reg_req.addr == OFS_SET |=> reg_rdata == REG_RESET
    ) else $error("set alias read nonzero");

    chk_gpio_only: assert property ( // R15
        ##1 (widen(pin_drive.oe) & ~$past(gpio_m) & DATA_MASK)
            == (widen($past(video_drive.oe)) & ~$past(gpio_m) & DATA_MASK)
    ) else $error("direction leaked onto video pin");

    // ==========================================================
    // Checks: stored values and read data
    chk_dir_write: assert property ( // R5
        reg_req.wr && reg_req.addr == OFS_DIR
        |=> st_ff.dir == ($past(reg_req.wdata) & DIR_WMASK)
    ) else $error("direction write not masked");

    chk_dir_store: assert property ( // R5
        (st_ff.dir & ~DIR_WMASK) == REG_RESET
        && (st_ff.func & ~FUNC_WMASK) == REG_RESET
    ) else $error("reserved select or direction bit stored");

    chk_dout_store: assert property ( // R11
        (st_ff.dout & ~DATA_MASK) == REG_RESET
    ) else $error("reserved output bit stored");

    chk_dir_read: assert property ( // R5
        reg_req.rd && reg_req.addr == OFS_DIR
        |=> reg_rdata == $past(st_ff.dir)
    ) else $error("direction read not register value");

    chk_in_write: assert property ( // R6
        reg_req.wr && reg_req.addr == OFS_IN
        |=> st_ff.dout == $past(st_ff.dout) && st_ff.dir == $past(st_ff.dir)
            && st_ff.func == $past(st_ff.func)
    ) else $error("write to input register changed state");

    chk_in_rdctl: assert property ( // R7
        reg_req.rd && reg_req.addr == OFS_IN
        |=> (reg_rdata & CTL_MASK) == (widen($past(st_ff.level)) & CTL_MASK)
    ) else $error("control pin levels misreported");

    chk_data_level: assert property ( // R8
        ((st_ff.sync2 ^ st_ff.sync3) & DATA_MASK[PIN_W-1:0]) == '0
        |=> (st_ff.level & DATA_MASK[PIN_W-1:0]) == ($past(st_ff.sync2) & DATA_MASK[PIN_W-1:0])
    ) else $error("data pin level not captured");

    chk_sync_chain: assert property ( // R18
        ##1 ((st_ff.sync2 == $past(st_ff.sync1)) && (st_ff.sync3 == $past(st_ff.sync2)))
    ) else $error("pin capture chain skipped a stage");

    chk_set_high: assert property ( // R13
        reg_req.wr && reg_req.addr == OFS_SET
        |=> (st_ff.dout & $past(reg_req.wdata) & DATA_MASK) == ($past(reg_req.wdata) & DATA_MASK)
    ) else $error("set alias bit not high");

    chk_clr_low: assert property ( // R14
        reg_req.wr && reg_req.addr == OFS_CLR
        |=> (st_ff.dout & $past(reg_req.wdata)) == REG_RESET
    ) else $error("clear alias bit not low");

    chk_set_zero: assert property ( // R17
        reg_req.wr && reg_req.addr == OFS_SET
        |=> (st_ff.dout & ~$past(reg_req.wdata)) == ($past(st_ff.dout) & ~$past(reg_req.wdata))
    ) else $error("set alias zero bit changed output");

    chk_clr_zero: assert property ( // R17
        reg_req.wr && reg_req.addr == OFS_CLR
        |=> (st_ff.dout & ~$past(reg_req.wdata)) == ($past(st_ff.dout) & ~$past(reg_req.wdata))
    ) else $error("clear alias zero bit changed output");

    chk_clr_read: assert property ( // R17
        reg_req.rd && reg_req.addr == OFS_CLR |=> reg_rdata == REG_RESET
    ) else $error("clear alias read nonzero");

    chk_out_hold: assert property ( // R11
        !(reg_req.wr && (reg_req.addr == OFS_OUT || reg_req.addr == OFS_SET
                         || reg_req.addr == OFS_CLR))
        |=> st_ff.dout == $past(st_ff.dout)
    ) else $error("output register changed without a write");

    chk_rdata_idle: assert property ( // R12
        !reg_req.rd |=> reg_rdata == REG_RESET
    ) else $error("read data present without a read");

    // ==========================================================
    // Checks: pin groups
    chk_grp_15_in: assert property ( // R1
        st_ff.func[FS_DATA_HI] && !st_ff.dir[DIR_D15_12]
        |=> (widen(pin_drive.oe) & GRP_D15_12) == REG_RESET
    ) else $error("data pins 15-12 driven while inputs");

    chk_grp_9_out: assert property ( // R2
        st_ff.func[FS_DATA_LO] && st_ff.dir[DIR_D9_8]
        |=> (widen(pin_drive.oe) & GRP_D9_8) == GRP_D9_8
    ) else $error("data pins 9-8 not driven as outputs");

    chk_grp_7_in: assert property ( // R3
        st_ff.func[FS_DATA_LO] && !st_ff.dir[DIR_D7_4]
        |=> (widen(pin_drive.oe) & GRP_D7_4) == REG_RESET
    ) else $error("data pins 7-4 driven while inputs");

    chk_grp_19_out: assert property ( // R16
        st_ff.func[FS_DATA_HI] && st_ff.dir[DIR_D19_16]
        |=> (widen(pin_drive.oe) & GRP_D19_16) == GRP_D19_16
    ) else $error("data pins 19-16 not driven as outputs");

    chk_grp_19_in: assert property ( // R16
        st_ff.func[FS_DATA_HI] && !st_ff.dir[DIR_D19_16]
        |=> (widen(pin_drive.oe) & GRP_D19_16) == REG_RESET
    ) else $error("data pins 19-16 driven while inputs");

    chk_oe_resv: assert property ( // R9
        (widen(pin_drive.oe) & ~DATA_MASK) == REG_RESET
    ) else $error("absent pin position driven");

endmodule : vpg_gpio

`default_nettype wire

// file: vpg_pkg.sv
// Constants and types for the video port pin GPIO block
`default_nettype none

package vpg_pkg;

    // ==========================================================
    // Widths
    localparam int unsigned REG_W  = 32;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned PIN_W  = 23;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] OFS_FUNC = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DIR  = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IN   = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_OUT  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_SET  = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_CLR  = 8'h14;

    // ==========================================================
    // Writable masks and reset values
    localparam logic [REG_W-1:0] FUNC_WMASK = 32'h0070_0401;
    localparam logic [REG_W-1:0] DIR_WMASK  = 32'h0071_1111;
    localparam logic [REG_W-1:0] DATA_MASK  = 32'h007F_F3FC;
    localparam logic [REG_W-1:0] REG_RESET  = 32'h0000_0000;

    // ==========================================================
    // Field positions
    localparam int unsigned FS_DATA_LO = 0;
    localparam int unsigned FS_DATA_HI = 10;
    localparam int unsigned DIR_D3_2   = 0;
    localparam int unsigned DIR_D7_4   = 4;
    localparam int unsigned DIR_D9_8   = 8;
    localparam int unsigned DIR_D15_12 = 12;
    localparam int unsigned DIR_D19_16 = 16;
    localparam logic [REG_W-1:0] CTL_MASK = 32'h0070_0000;

    // ==========================================================
    // Pin groups
    localparam logic [REG_W-1:0] GRP_D3_2   = 32'h0000_000C;
    localparam logic [REG_W-1:0] GRP_D7_4   = 32'h0000_00F0;
    localparam logic [REG_W-1:0] GRP_D9_8   = 32'h0000_0300;
    localparam logic [REG_W-1:0] GRP_D15_12 = 32'h0000_F000;
    localparam logic [REG_W-1:0] GRP_D19_16 = 32'h000F_0000;
    localparam logic [REG_W-1:0] GRP_D9_2   = 32'h0000_03FC;
    localparam logic [REG_W-1:0] GRP_D19_12 = 32'h000F_F000;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [REG_W-1:0]  wdata;
        logic              wr;
        logic              rd;
    } vpg_req_t;

    typedef struct packed {
        logic [PIN_W-1:0] out;
        logic [PIN_W-1:0] oe;
    } vpg_pin_t;

endpackage : vpg_pkg

`default_nettype wire

// file: vpg_pin_model.sv
// Far-side model: external circuitry sharing the video port pins
`timescale 1ns/1ps
`default_nettype none

module vpg_pin_model
    import vpg_pkg::*;
(
    input  wire vpg_pkg::vpg_pin_t pin_drive,
    input  wire logic [22:0]       ext_lvl,
    output var  logic [22:0]       pin_in
);
    import vpg_pkg::*;

    // ==========================================================
    // Wire level
    // Device drive wins where enabled, else the far side holds the line
    always_comb begin
        for (int i = 0; i < 23; i++) begin
            pin_in[i] = pin_drive.oe[i] ? pin_drive.out[i] : ext_lvl[i];
        end
    end

endmodule : vpg_pin_model

`default_nettype wire

// file: test_video_port_gpio_data_path.sv
// Self-checking bench for the video port pin GPIO block
`timescale 1ns/1ps
`default_nettype none

module test_video_port_gpio_data_path;
    import vpg_pkg::*;

    logic        core_clk;
    logic        rstn;
    vpg_req_t    reg_req;
    logic [31:0] reg_rdata;
    logic [22:0] pin_in;
    logic [22:0] ext_lvl;
    vpg_pin_t    video_drive;
    vpg_pin_t    pin_drive;
    vpg_pin_t    want;
    logic [31:0] exp_q[$];
    logic        rd_q;
    int          n_fail;
    int          num_checks;
    int          cyc_cnt;
    logic [31:0] fsel, dir, dout, r, s, c;
    logic [7:0]  ofs [7] = '{OFS_FUNC, OFS_DIR, OFS_IN, OFS_OUT, OFS_SET, OFS_CLR, 8'h18};

    vpg_gpio i_vpg_gpio (.core_clk(core_clk), .rstn(rstn), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .pin_in(pin_in), .video_drive(video_drive),
        .pin_drive(pin_drive));
    vpg_pin_model i_vpg_pin_model (.pin_drive(pin_drive), .ext_lvl(ext_lvl),
        .pin_in(pin_in));

    // ==========================================================
    // Clock, timeout, read monitor
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        rd_q <= reg_req.rd;
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 2000) begin
            n_fail++;
            close_out();
        end
    end

    // Read data stands only one cycle, so look in that cycle
    always @(negedge core_clk) begin
        if (rd_q === 1'b1) begin
            cmp("reg_rdata", exp_q.pop_front(), reg_rdata);
        end
    end

    // ==========================================================
    // Tasks
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] v);
        num_checks++;
        if (v !== e) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, e, v);
        end
    endtask : cmp

    task automatic acc(input logic w, input logic rd, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_req <= '{addr: a, wdata: d, wr: w, rd: rd};
    endtask : acc

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        acc(1'b1, 1'b0, a, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        acc(1'b0, 1'b1, a, 32'h0000_0000);
        exp_q.push_back(e);
    endtask : rd_chk

    task automatic idle(input int n);
        repeat (n) begin
            @(posedge core_clk);
            reg_req <= '0;
        end
    endtask : idle

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    // Pins 0, 1, 10 and 11 do not exist, so they never drive
    function automatic vpg_pin_t pins_exp(input logic [31:0] f, input logic [31:0] d,
                                          input logic [31:0] o, input vpg_pin_t v);
        logic g;
        logic b;
        pins_exp = '0;
        for (int i = 2; i < 23; i++) begin
            g = (i < 10) ? f[0] : (i < 20) ? f[10] : f[i];
            b = (i < 4) ? d[0] : (i < 8) ? d[4] : (i < 10) ? d[8] :
                (i < 16) ? d[12] : (i < 20) ? d[16] : d[i];
            if (i != 10 && i != 11) begin
                pins_exp.oe[i] = g ? b : v.oe[i];
                pins_exp.out[i] = g ? o[i] : v.out[i];
            end
        end
    endfunction : pins_exp

    // ==========================================================
    // Main sequence
    initial begin
        rstn = 1'b0;
        reg_req = '0;
        video_drive = '0;
        ext_lvl = '0;
        n_fail = 0;
        num_checks = 0;
        cyc_cnt = 0;
        r = $urandom(32'hE4044D95);
        repeat (4) @(posedge core_clk);
        rstn <= 1'b1;
        for (int k = 0; k < 7; k++) rd_chk(ofs[k], REG_RESET);
        idle(2);
        $display("test reset done");
        r = $urandom();
        s = $urandom();
        c = $urandom();
        wr(OFS_DIR, 32'hFFFF_FFFF);
        rd_chk(OFS_DIR, DIR_WMASK);
        wr(OFS_OUT, r);
        wr(OFS_IN, 32'hFFFF_FFFF);
        wr(8'h18, 32'hFFFF_FFFF);
        rd_chk(OFS_OUT, r & DATA_MASK);
        wr(OFS_SET, s);
        rd_chk(OFS_OUT, (r | s) & DATA_MASK);
        wr(OFS_CLR, c);
        rd_chk(OFS_OUT, (r | s) & ~c & DATA_MASK);
        rd_chk(OFS_SET, 32'h0000_0000);
        rd_chk(OFS_IN, 32'h0000_0000);
        rd_chk(8'h18, 32'h0000_0000);
        rd_chk(OFS_CLR, 32'h0000_0000);
        wr(OFS_FUNC, 32'hFFFF_FFFF);
        rd_chk(OFS_FUNC, FUNC_WMASK);
        wr(OFS_SET, c);
        wr(OFS_CLR, c);
        rd_chk(OFS_OUT, (r | s) & ~c & DATA_MASK);
        idle(2);
        $display("test registers done");
        for (int n = 0; n < 10; n++) begin
            fsel = $urandom();
            dir = $urandom();
            dout = $urandom();
            video_drive.out <= 23'($urandom());
            video_drive.oe <= 23'($urandom());
            ext_lvl <= 23'($urandom());
            wr(OFS_FUNC, fsel);
            wr(OFS_DIR, dir);
            wr(OFS_OUT, dout);
            idle(3);
            @(negedge core_clk);
            want = pins_exp(fsel, dir, dout, video_drive);
            cmp("pin oe", 32'(want.oe), 32'(pin_drive.oe));
            cmp("pin out", 32'(want.out & want.oe), 32'(pin_drive.out & pin_drive.oe));
            r = 32'((want.oe & want.out) | (~want.oe & ext_lvl));
            s = 32'((want.oe & want.out) | (~want.oe & ~ext_lvl));
            idle(6);
            rd_chk(OFS_IN, r & DATA_MASK);
            ext_lvl <= ~ext_lvl;
            rd_chk(OFS_IN, r & DATA_MASK);
            idle(6);
            rd_chk(OFS_IN, s & DATA_MASK);
        end
        idle(2);
        $display("test pins done");
        close_out();
    end

endmodule : test_video_port_gpio_data_path

`default_nettype wire
